// >>> fst_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Current-below flag tracks current under target; drives alarm.
// - Hot-die flag sets over upper, clears under release; alarms.
// - Warm-die flag sets above warning, clears below release; no alarm.
// - Supply-low flag follows sense under lower threshold; alarms.
// - Supply-sag flag follows sense below higher threshold; no alarm.
// - Status low byte carries the 8-bit monitor result.
// - Supply monitor code equals volts times 256/2.5.
// - Temperature degrees equal 125 minus 1.771 times (code - 128).
// - Zero-point trim is 16-bit read/write, reset 32768.
// - Offset correction equals zero-point trim minus 32768 LSBs.
// - Span trim is 16-bit read/write, reset 65535.
// - Full-scale reduced by 65535 minus span trim LSBs.
// - Code scaled by span over 2^16, then offset added.
// - Negative offset never takes output below zero scale; clamp.
// - Status register is read-only; writes ignored.
module fst_regs (
    input  wire logic                          sys_clk_in,
    input  wire logic                          nrst_in,
    input  wire logic [fst_pkg::ADDR_W-1:0]    reg_addr_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    input  wire logic [15:0]                   reg_wdata_in,
    output var  logic [15:0]                   reg_rdata_out,
    output var  logic                          reg_rvalid_out,
    input  wire logic                          current_below_in,
    input  wire logic                          current_above_in,
    input  wire logic                          temp_above_hot_in,
    input  wire logic                          temp_below_hot_rel_in,
    input  wire logic                          temp_above_warm_in,
    input  wire logic                          temp_below_warm_rel_in,
    input  wire logic                          supply_below_low_in,
    input  wire logic                          supply_below_sag_in,
    input  wire logic [fst_pkg::MON_W-1:0]     monitor_code_in,
    input  wire logic                          monitor_valid_in,
    input  wire logic [15:0]                   dac_code_in,
    output var  logic [15:0]                   corrected_code_out,
    output var  logic                          alarm_out
);
    logic [fst_pkg::SYNC_W-1:0] cmp_sync;
    logic                       current_below_flag;
    logic                       current_above_flag;
    logic                       hot_flag;
    logic                       warm_flag;
    logic                       supply_low_flag;
    logic                       supply_sag_flag;
    logic [fst_pkg::MON_W-1:0]  monitor_code;
    logic [15:0]                zero_point_trim;
    logic [15:0]                span_trim;
    logic [15:0]                status_word;
    logic [31:0]                product;
    logic [17:0]                next_sum;
    logic [15:0]                next_code;
    logic [2:0]                 reg_sel;

    // Address decode shared by the write and read ports
    function automatic logic [2:0] reg_select(
        input logic [fst_pkg::ADDR_W-1:0] addr
    );
        logic [2:0] sel;
        case (addr)
            fst_pkg::ADDR_STATUS: begin
                sel = 3'h1;
            end
            fst_pkg::ADDR_ZERO_TRIM: begin
                sel = 3'h2;
            end
            fst_pkg::ADDR_SPAN_TRIM: begin
                sel = 3'h4;
            end
            default: begin
                sel = 3'h0;
            end
        endcase
        return sel;
    endfunction

    assign reg_sel = reg_select(reg_addr_in);

    // Comparator inputs through a two-stage synchroniser
    fst_sync #(
        .W (fst_pkg::SYNC_W)
    ) fst_sync_i (
        .sys_clk_in (sys_clk_in),
        .nrst_in    (nrst_in),
        .d_in       ({current_below_in, current_above_in,
                      temp_above_hot_in, temp_below_hot_rel_in,
                      temp_above_warm_in, temp_below_warm_rel_in,
                      supply_below_low_in, supply_below_sag_in}),
        .q_out      (cmp_sync)
    );

    // Level flags follow the synchronised conditions
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            current_below_flag <= 1'b0;
            current_above_flag <= 1'b0;
            supply_low_flag    <= 1'b0;
            supply_sag_flag    <= 1'b0;
        end else begin
            current_below_flag <= cmp_sync[7];
            current_above_flag <= cmp_sync[6];
            supply_low_flag    <= cmp_sync[1];
            supply_sag_flag    <= cmp_sync[0];
        end
    end

    // Temperature flags with hysteresis
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            hot_flag  <= 1'b0;
            warm_flag <= 1'b0;
        end else begin
            if (cmp_sync[5]) begin
                hot_flag <= 1'b1;
            end else if (cmp_sync[4]) begin
                hot_flag <= 1'b0;
            end
            if (cmp_sync[3]) begin
                warm_flag <= 1'b1;
            end else if (cmp_sync[2]) begin
                warm_flag <= 1'b0;
            end
        end
    end

    // Monitor result, captured unchanged while monitor_valid_in is high
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            monitor_code <= '0;
        end else if (monitor_valid_in) begin
            monitor_code <= monitor_code_in;
        end
    end

    // Alarm pin: warm and sag flags excluded
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            alarm_out <= 1'b0;
        end else begin
            alarm_out <= current_below_flag
                       | current_above_flag
                       | hot_flag
                       | supply_low_flag;
        end
    end

    // Trim registers; status address takes no write
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            zero_point_trim <= fst_pkg::ZERO_TRIM_RST;
            span_trim       <= fst_pkg::SPAN_TRIM_RST;
        end else if (reg_wr_in) begin
            case (reg_sel)
                3'h2: begin
                    zero_point_trim <= reg_wdata_in;
                end
                3'h4: begin
                    span_trim <= reg_wdata_in;
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        status_word = '0;
        status_word[fst_pkg::BIT_ABOVE] = current_above_flag;
        status_word[fst_pkg::BIT_BELOW] = current_below_flag;
        status_word[fst_pkg::BIT_HOT]   = hot_flag;
        status_word[fst_pkg::BIT_WARM]  = warm_flag;
        status_word[fst_pkg::BIT_LOW]   = supply_low_flag;
        status_word[fst_pkg::BIT_SAG]   = supply_sag_flag;
        status_word[fst_pkg::MON_W-1:0] = monitor_code;
    end

    // Read port: one-cycle registered answer, unmapped reads zero
    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            reg_rdata_out  <= '0;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in) begin
                case (reg_sel)
                    3'h1: begin
                        reg_rdata_out <= status_word;
                    end
                    3'h2: begin
                        reg_rdata_out <= zero_point_trim;
                    end
                    3'h4: begin
                        reg_rdata_out <= span_trim;
                    end
                    default: begin
                        reg_rdata_out <= '0;
                    end
                endcase
            end
        end
    end

    // Gain then offset correction, clamped to the code range
    always_comb begin
        product  = 32'(dac_code_in) * 32'(span_trim);
        next_sum = {2'b00, product[31:16]} + {2'b00, zero_point_trim}
                 - fst_pkg::ZERO_TRIM_MID;
        if (next_sum[17]) begin
            next_code = '0;
        end else if (next_sum[16]) begin
            next_code = fst_pkg::CODE_MAX;
        end else begin
            next_code = next_sum[15:0];
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            corrected_code_out <= '0;
        end else begin
            corrected_code_out <= next_code;
        end
    end
endmodule
`default_nettype wire

// >>> fst_pkg.sv
`default_nettype none
package fst_pkg;
    localparam int          ADDR_W          = 4;
    localparam logic [3:0]  ADDR_STATUS     = 4'h5;
    localparam logic [3:0]  ADDR_ZERO_TRIM  = 4'h8;
    localparam logic [3:0]  ADDR_SPAN_TRIM  = 4'h9;
    localparam logic [15:0] ZERO_TRIM_RST   = 16'h8000;
    localparam logic [15:0] SPAN_TRIM_RST   = 16'hFFFF;
    localparam logic [17:0] ZERO_TRIM_MID   = 18'h08000;
    localparam logic [15:0] CODE_MAX        = 16'hFFFF;
    localparam int          BIT_ABOVE       = 13;
    localparam int          BIT_BELOW       = 12;
    localparam int          BIT_HOT         = 11;
    localparam int          BIT_WARM        = 10;
    localparam int          BIT_LOW         = 9;
    localparam int          BIT_SAG         = 8;
    localparam int          MON_W           = 8;
    localparam int          SYNC_W          = 8;
endpackage
`default_nettype wire

// >>> fst_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fst_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk_in,
    input  wire logic         nrst_in,
    input  wire logic [W-1:0] d_in,
    output var  logic [W-1:0] q_out
);
    logic [W-1:0] meta;

    always_ff @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta  <= '0;
            q_out <= '0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule
`default_nettype wire

// >>> fst_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fst_regs_asserts (
    input wire logic                       sys_clk_in,
    input wire logic                       nrst_in,
    input wire logic [fst_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic                       reg_rd_in,
    input wire logic [15:0]                reg_rdata_out,
    input wire logic                       reg_rvalid_out,
    input wire logic                       current_below_in,
    input wire logic                       current_above_in,
    input wire logic                       temp_above_hot_in,
    input wire logic                       temp_below_hot_rel_in,
    input wire logic                       supply_below_low_in,
    input wire logic [fst_pkg::MON_W-1:0]  monitor_code_in,
    input wire logic                       monitor_valid_in,
    input wire logic                       alarm_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_quiet;
        !current_below_in && !current_above_in && !supply_below_low_in
            && !temp_above_hot_in && temp_below_hot_rel_in;
    endsequence
    sequence s_st_rd;
        reg_rd_in && reg_addr_in == fst_pkg::ADDR_STATUS;
    endsequence
    sequence s_mon_rd;
        monitor_valid_in ##1 !monitor_valid_in ##1 s_st_rd;
    endsequence
    property p_below; current_below_in [*4] |=> alarm_out; endproperty
    property p_hot; temp_above_hot_in [*4] |=> alarm_out; endproperty
    property p_low; supply_below_low_in [*4] |=> alarm_out; endproperty
    property p_quiet; s_quiet [*5] |=> !alarm_out; endproperty
    property p_rv; reg_rd_in |=> reg_rvalid_out; endproperty
    property p_norv; !reg_rd_in |=> !reg_rvalid_out; endproperty
    property p_top; s_st_rd |=> reg_rdata_out[15:14] == 2'b00; endproperty
    property p_mon;
        s_mon_rd |=> reg_rdata_out[7:0] == $past(monitor_code_in, 3);
    endproperty
    a_below: assert property (p_below)
        else $error("alarm missing for low current");
    a_hot: assert property (p_hot)
        else $error("alarm missing for hot die");
    a_low: assert property (p_low)
        else $error("alarm missing for low supply");
    a_quiet: assert property (p_quiet)
        else $error("alarm without alarming cause");
    a_rv: assert property (p_rv)
        else $error("read not answered");
    a_norv: assert property (p_norv)
        else $error("answer without read");
    a_top: assert property (p_top)
        else $error("status top bits not zero");
    a_mon: assert property (p_mon)
        else $error("monitor code not in status");
endmodule
bind fst_regs fst_regs_asserts fst_regs_asserts_i (.sys_clk_in, .nrst_in,
    .reg_addr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out,
    .current_below_in, .current_above_in, .temp_above_hot_in,
    .temp_below_hot_rel_in, .supply_below_low_in, .monitor_code_in,
    .monitor_valid_in, .alarm_out);
`default_nettype wire

// >>> fst_host.sv
`timescale 1ns/1ps
`default_nettype none
module fst_host (
    input  wire logic        sys_clk_in,
    input  wire logic [15:0] rdata_in,
    input  wire logic        rvalid_in,
    output var  logic [3:0]  addr_out,
    output var  logic        wr_out,
    output var  logic        rd_out,
    output var  logic [15:0] wdata_out
);
    initial begin
        addr_out = 4'h0;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 16'h0000;
    end
    // Released lines show the inverse of the last value
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge sys_clk_in);
        wr_out <= 1'b0;
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge sys_clk_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        d = 16'hXXXX;
        // Answer taken at the edge where rvalid is sampled high
        for (int n = 0; n < 4; n++) begin
            @(posedge sys_clk_in);
            if (rvalid_in === 1'b1) begin
                d = rdata_in;
                break;
            end
        end
    endtask
endmodule
`default_nettype wire

// >>> fault_status_and_trim_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module fault_status_and_trim_regs_bench;
    logic        sys_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic [3:0]  addr;
    logic        wr;
    logic        rd;
    logic        rvalid;
    logic        alarm;
    logic        mv      = 1'b0;
    logic [7:0]  mon     = 8'h00;
    logic [7:0]  fl      = 8'hC0;
    logic [15:0] dac     = 16'h0000;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] cor;
    logic [15:0] v;
    logic [5:0]  am      = 6'b111010;
    logic [15:0] ct [4][4] = '{'{16'h1234, 16'hFFFF, 16'h8000, 16'h1233},
        '{16'hFFFF, 16'h8000, 16'h8001, 16'h8000},
        '{16'h0100, 16'hFFFF, 16'h0000, 16'h0000},
        '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF}};
    int          errors  = 0;
    int          checks  = 0;
    always #2.5 sys_clk = ~sys_clk;
    fst_regs fst_regs_i (.sys_clk_in(sys_clk), .nrst_in(rst_n),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .current_below_in(fl[4]), .current_above_in(fl[5]),
        .temp_above_hot_in(fl[3]), .temp_below_hot_rel_in(fl[7]),
        .temp_above_warm_in(fl[2]), .temp_below_warm_rel_in(fl[6]),
        .supply_below_low_in(fl[1]), .supply_below_sag_in(fl[0]),
        .monitor_code_in(mon), .monitor_valid_in(mv), .dac_code_in(dac),
        .corrected_code_out(cor), .alarm_out(alarm));
    fst_host fst_host_i (.sys_clk_in(sys_clk), .rdata_in(rdata),
        .rvalid_in(rvalid), .addr_out(addr), .wr_out(wr), .rd_out(rd),
        .wdata_out(wdata));
    task automatic cmp_w(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: word %h expected %h", $time, g, e);
        end
    endtask
    task automatic cmp_b(input logic g, input logic e);
        checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: alarm %b expected %b", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e);
        fst_host_i.rd(a, v);
        cmp_w(v, e);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    initial begin
        settle(10);
        rst_n <= 1'b1;
        rdc(fst_pkg::ADDR_ZERO_TRIM, 16'h8000);
        rdc(fst_pkg::ADDR_SPAN_TRIM, 16'hFFFF);
        rdc(fst_pkg::ADDR_STATUS, 16'h0000);
        $display("test reset done");
        fst_host_i.wr(fst_pkg::ADDR_ZERO_TRIM, 16'h1234);
        fst_host_i.wr(fst_pkg::ADDR_SPAN_TRIM, 16'hA5C3);
        fst_host_i.wr(fst_pkg::ADDR_STATUS, 16'hFFFF);
        fst_host_i.wr(4'h3, 16'h5A5A);
        rdc(fst_pkg::ADDR_ZERO_TRIM, 16'h1234);
        rdc(fst_pkg::ADDR_SPAN_TRIM, 16'hA5C3);
        rdc(fst_pkg::ADDR_STATUS, 16'h0000);
        rdc(4'h3, 16'h0000);
        $display("test access done");
        for (int i = 0; i < 4; i++) begin
            fst_host_i.wr(fst_pkg::ADDR_SPAN_TRIM, ct[i][1]);
            fst_host_i.wr(fst_pkg::ADDR_ZERO_TRIM, ct[i][2]);
            @(posedge sys_clk);
            dac <= ct[i][0];
            settle(3);
            #1 cmp_w(cor, ct[i][3]);
        end
        $display("test trim done");
        for (int i = 0; i < 6; i++) begin
            @(posedge sys_clk);
            fl <= 8'hC0 | (8'h01 << i);
            settle(6);
            rdc(fst_pkg::ADDR_STATUS, {2'b00, 6'h01 << i, 8'h00});
            cmp_b(alarm, am[i]);
        end
        @(posedge sys_clk);
        fl <= 8'h08;
        settle(6);
        fl <= 8'h00;
        settle(6);
        rdc(fst_pkg::ADDR_STATUS, 16'h0800);
        cmp_b(alarm, 1'b1);
        fl <= 8'hC0;
        settle(6);
        rdc(fst_pkg::ADDR_STATUS, 16'h0000);
        cmp_b(alarm, 1'b0);
        $display("test flags done");
        @(posedge sys_clk);
        mon <= 8'hA5;
        mv <= 1'b1;
        @(posedge sys_clk);
        mv <= 1'b0;
        rdc(fst_pkg::ADDR_STATUS, 16'h00A5);
        $display("test monitor done");
        end_sim();
    end
    initial begin
        settle(5000);
        errors++;
        end_sim();
    end
endmodule
`default_nettype wire
